// ### rtl/sram_ctrl_pkg.sv
/*
  Shared constants and types for the synchronous burst memory control block.
  Assumes a single 40 MHz clock shared with the memory controller and an APB master.
*/
`default_nettype none

package sram_ctrl_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int ADDR_W = 4;
  localparam int DEPTH = 16;
  localparam int BURST_W = 2;
  localparam int APB_AW = 12;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [APB_AW-1:0] CTRL_OFS = 12'h000;
  localparam logic [APB_AW-1:0] STATUS_OFS = 12'h004;
  localparam int CTRL_ORDER_BIT = 0;
  localparam int CTRL_BYPASS_N_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h2;
  localparam int STAT_CYC_LSB = 0;
  localparam int STAT_LOW_LSB = 4;
  localparam int STAT_SLEEP_BIT = 8;
  localparam int STAT_PD_BIT = 9;
  localparam int STAT_DRIVE_BIT = 10;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h0;
  localparam logic [LANES-1:0] OE_RST = 4'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CYC_DESELECT,
    CYC_READ,
    CYC_WRITE
  } cyc_e;

  typedef struct packed {
    logic chip_select_n;
    logic processor_strobe_n;
    logic controller_strobe_n;
    logic burst_advance_n;
    logic global_write_n;
    logic lane_write_gate_n;
    logic lane_a_write_n;
    logic lane_b_write_n;
    logic lane_c_write_n;
    logic lane_d_write_n;
  } ctl_pins_s;

endpackage

`default_nettype wire

// ### rtl/burst_addr_gen.sv
/*
  Two-bit burst address sequencer, linear or interleaved.
  Assumes load and step are never both acted on: load wins.
*/
`timescale 1ns/1ps
`default_nettype none

module burst_addr_gen
  import sram_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic step,
  input wire logic order_sel,
  input wire logic [BURST_W-1:0] start_low,
  output logic [BURST_W-1:0] low_used
);

  logic [BURST_W-1:0] base_r;
  logic [BURST_W-1:0] base_nxt;
  logic [BURST_W-1:0] cnt_r;
  logic [BURST_W-1:0] cnt_nxt;

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  always_comb begin
    base_nxt = base_r;
    cnt_nxt = cnt_r;
    if (load) begin
      base_nxt = start_low;
      cnt_nxt = BURST_RST;
    end else if (step) begin
      // Counter is two bits wide, so the fifth clock returns to the start
      cnt_nxt = cnt_r + 2'h1;
    end
    if (order_sel) begin
      low_used = base_nxt ^ cnt_nxt;
    end else begin
      low_used = base_nxt + cnt_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      base_r <= BURST_RST;
      cnt_r <= BURST_RST;
    end else begin
      base_r <= base_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule

`default_nettype wire

// ### rtl/sync_burst_sram_control.sv
/*
  Command decode, burst addressing, byte-lane writes and data drivers of a
  synchronous burst memory, with mode control and status over APB.
  Assumes the memory controller shares pclk; output enable and sleep are async.
*/
//
// Contract
// - Burst counter returns to start address on fifth clock; four locations per burst.
// - Reads drive every data byte lane regardless of lane write enables.
// - Write when global write low, or gate low with any lane enable low.
// - Data lanes float throughout every write.
// - Chip select high with controller strobe low deselects, powers down, floats bus.
// - Selected with processor strobe low starts read burst at external address.
// - Selected, processor strobe high, controller strobe low begins burst, read or write.
// - Both strobes inactive with advance low steps burst address, read or write.
// - Same strobes with advance high keeps current address, read or write.
// - Output enable high turns drivers off asynchronously; low only allows read drive.
// - Every listed control combination is supported.
// - Dummy reads with output enable high advance the burst counter normally.
// - Burst order select low is linear, high is interleaved on two low bits.
// - Bypass low gives flow-through reads, high gives registered reads.
`timescale 1ns/1ps
`default_nettype none

module sync_burst_sram_control
  import sram_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ctl_pins_s ctl,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  output logic [DATA_W-1:0] dq_out,
  output logic [LANES-1:0] dq_oe,
  output logic power_down
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic sleep_meta_r;
  logic sleep_s_r;
  logic oe_meta_r;
  logic oe_s_r;
  logic [1:0] ctrl_r;
  logic [1:0] ctrl_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  cyc_e cyc;
  cyc_e state_r;
  logic load;
  logic step;
  logic desel;
  logic wr_dec;
  logic [LANES-1:0] lane_n;
  logic [LANES-1:0] lane_we;
  logic [BURST_W-1:0] low_used;
  logic [ADDR_W-BURST_W-1:0] hi_r;
  logic [ADDR_W-BURST_W-1:0] hi_nxt;
  logic [ADDR_W-1:0] used_addr;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] stage_r;
  logic [DATA_W-1:0] stage_nxt;
  logic stage_rd_r;
  logic stage_rd_nxt;
  logic [DATA_W-1:0] dq_out_r;
  logic [DATA_W-1:0] dq_out_nxt;
  logic drive_nxt;
  logic [LANES-1:0] dq_oe_r;
  logic [LANES-1:0] dq_oe_nxt;
  logic power_down_r;
  logic reg_wr;
  logic bypass_n;

  assign bypass_n = ctrl_r[CTRL_BYPASS_N_BIT];

  // ----------------------------------------------------------------
  // Async pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_meta_r <= 1'b0;
      sleep_s_r <= 1'b0;
      oe_meta_r <= 1'b1;
      oe_s_r <= 1'b1;
    end else begin
      sleep_meta_r <= sleep_request;
      sleep_s_r <= sleep_meta_r;
      oe_meta_r <= output_enable_n;
      oe_s_r <= oe_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  always_comb begin
    lane_n = {ctl.lane_d_write_n, ctl.lane_c_write_n, ctl.lane_b_write_n, ctl.lane_a_write_n};
    wr_dec = !ctl.global_write_n || (!ctl.lane_write_gate_n && !(&lane_n));
    lane_we = '0;
    if (!ctl.global_write_n) begin
      lane_we = '1;
    end else if (!ctl.lane_write_gate_n) begin
      lane_we = ~lane_n;
    end
    desel = 1'b0;
    load = 1'b0;
    step = 1'b0;
    cyc = CYC_DESELECT;
    // Every combination below is decoded, optional ones included
    if (sleep_s_r) begin
      desel = 1'b1;
    end else if (!ctl.chip_select_n && !ctl.processor_strobe_n) begin
      load = 1'b1;
      cyc = CYC_READ;
    end else if (ctl.chip_select_n && !ctl.controller_strobe_n) begin
      desel = 1'b1;
    end else if (!ctl.controller_strobe_n) begin
      load = 1'b1;
      cyc = wr_dec ? CYC_WRITE : CYC_READ;
    end else begin
      // Advance ignores output enable, so dummy reads step too
      step = !ctl.burst_advance_n;
      cyc = wr_dec ? CYC_WRITE : CYC_READ;
    end
    hi_nxt = load ? addr[ADDR_W-1:BURST_W] : hi_r;
  end

  burst_addr_gen u_burst (
    .clk(pclk),
    .rst_n(presetn),
    .load(load),
    .step(step),
    .order_sel(ctrl_r[CTRL_ORDER_BIT]),
    .start_low(addr[BURST_W-1:0]),
    .low_used(low_used)
  );

  assign used_addr = {hi_nxt, low_used};
  assign rd_word = mem[used_addr];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Array has no reset: contents are undefined until written
  always_ff @(posedge pclk) begin
    for (int i = 0; i < LANES; i++) begin
      if (cyc == CYC_WRITE && lane_we[i]) begin
        mem[used_addr][i*LANE_W +: LANE_W] <= dq_in[i*LANE_W +: LANE_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path and drivers
  // ----------------------------------------------------------------
  always_comb begin
    stage_nxt = rd_word;
    stage_rd_nxt = (cyc == CYC_READ);
    if (!bypass_n) begin
      dq_out_nxt = (cyc == CYC_READ) ? rd_word : dq_out_r;
      drive_nxt = (cyc == CYC_READ);
    end else begin
      // Registered mode: data of last cycle's read, but a deselect or
      // write now cuts the drive at once instead of one stage later
      dq_out_nxt = stage_rd_r ? stage_r : dq_out_r;
      drive_nxt = stage_rd_r && (cyc == CYC_READ);
    end
    dq_oe_nxt = (drive_nxt && !oe_s_r) ? '1 : '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_r <= DATA_RST;
      stage_rd_r <= 1'b0;
      dq_out_r <= DATA_RST;
      hi_r <= ADDR_RST[ADDR_W-1:BURST_W];
      state_r <= CYC_DESELECT;
      power_down_r <= 1'b1;
    end else begin
      stage_r <= stage_nxt;
      stage_rd_r <= stage_rd_nxt;
      dq_out_r <= dq_out_nxt;
      hi_r <= hi_nxt;
      state_r <= cyc;
      power_down_r <= desel;
    end
  end

  // Output enable high clears the drivers without waiting for a clock
  always_ff @(posedge pclk or negedge presetn or posedge output_enable_n) begin
    if (!presetn) begin
      dq_oe_r <= OE_RST;
    end else if (output_enable_n) begin
      dq_oe_r <= OE_RST;
    end else begin
      dq_oe_r <= dq_oe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  always_comb begin
    reg_wr = psel && penable && pready_r && pwrite && !pslverr_r;
    ctrl_nxt = ctrl_r;
    if (reg_wr && paddr == CTRL_OFS) begin
      ctrl_nxt = pwdata[1:0];
    end
    pready_nxt = psel && !penable;
    pslverr_nxt = psel && !penable && paddr != CTRL_OFS && paddr != STATUS_OFS;
    prdata_nxt = prdata_r;
    if (psel && !penable) begin
      prdata_nxt = '0;
      if (paddr == CTRL_OFS) begin
        prdata_nxt[1:0] = ctrl_r;
      end else if (paddr == STATUS_OFS) begin
        prdata_nxt[STAT_CYC_LSB +: 2] = state_r;
        prdata_nxt[STAT_LOW_LSB +: BURST_W] = low_used;
        prdata_nxt[STAT_SLEEP_BIT] = sleep_s_r;
        prdata_nxt[STAT_PD_BIT] = power_down_r;
        prdata_nxt[STAT_DRIVE_BIT] = |dq_oe_r;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign dq_out = dq_out_r;
  assign dq_oe = dq_oe_r;
  assign power_down = power_down_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_BURST_WRAP: assert property (
    @(posedge pclk) disable iff (!presetn)
    (step && !reg_wr)[*4] |-> (low_used == $past(low_used, 4)))
    else $error("burst address did not wrap after four steps");

  AST_ALL_LANES: assert property (
    @(posedge pclk) disable iff (!presetn)
    (dq_oe_r != OE_RST) |-> (dq_oe_r == 4'hf))
    else $error("read drive not on every lane");

  AST_WRITE_DECODE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!sleep_s_r && ctl.processor_strobe_n && !ctl.chip_select_n && !ctl.global_write_n)
      |=> (state_r == CYC_WRITE))
    else $error("global write not taken as write");

  AST_WRITE_FLOAT: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_r == CYC_WRITE) |-> (dq_oe_r == OE_RST))
    else $error("bus driven during write");

  AST_DESELECT: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ctl.chip_select_n && !ctl.controller_strobe_n)
      |=> (power_down_r && dq_oe_r == OE_RST && state_r == CYC_DESELECT))
    else $error("deselect not honoured");

  AST_PROC_READ: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!sleep_s_r && !ctl.chip_select_n && !ctl.processor_strobe_n)
      |-> (used_addr == addr) ##1 (state_r == CYC_READ))
    else $error("processor strobe did not start read at external address");

  AST_CTRL_BEGIN: assert property (
    @(posedge pclk) disable iff (!presetn)
    (load && ctl.processor_strobe_n) |-> (used_addr == addr))
    else $error("controller strobe burst not at external address");

  AST_SUSPEND: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!sleep_s_r && ctl.processor_strobe_n && ctl.controller_strobe_n && ctl.burst_advance_n)
      |-> (used_addr == {hi_r, $past(low_used)}))
    else $error("suspend changed the burst address");

  AST_OE_OFF: assert property (
    @(posedge pclk) disable iff (!presetn)
    output_enable_n |-> (dq_oe_r == OE_RST))
    else $error("drivers on while output enable high");

  AST_FLOW_DATA: assert property (
    @(posedge pclk) disable iff (!presetn)
    (cyc == CYC_READ && !bypass_n) |=> (dq_out_r == $past(rd_word)))
    else $error("flow-through data not presented next cycle");

  AST_PIPE_DATA: assert property (
    @(posedge pclk) disable iff (!presetn)
    (cyc == CYC_READ && bypass_n && !reg_wr) |-> ##2 (dq_out_r == $past(rd_word, 2)))
    else $error("registered data not one clock later");

endmodule

`default_nettype wire

// ### sim/host_model.sv
/*
  Behavioural memory controller driving the pin side of the burst memory block.
  Assumes the bench calls pin() between edges and shares pclk with the block.
*/
`timescale 1ns/1ps
`default_nettype none

module host_model
  import sram_ctrl_pkg::*;
(
  input wire logic pclk,
  output var ctl_pins_s ctl,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] dq_in,
  output logic output_enable_n
);
  initial begin
    ctl = ctl_pins_s'(10'h37f);
    addr = 4'h0;
    dq_in = 36'h0;
    output_enable_n = 1'b0;
  end

  // One command per edge; fixed strobe codes give single-cycle or simple bursts
  task automatic pin(input logic [9:0] c, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    ctl_pins_s s;
    logic wr;
    s = ctl_pins_s'(c);
    wr = !s.global_write_n || (!s.lane_write_gate_n && !(&c[3:0]));
    @(posedge pclk);
    ctl <= s;
    addr <= a;
    if (wr) begin
      dq_in <= d;
    end else begin
      // Undriven data lines toggle so stale data can never pass as written
      dq_in <= ~dq_in;
    end
    #1;
  endtask

  // Output enable moves on an edge; the command already on the pins stays and repeats
  task automatic set_oe(input logic v);
    @(posedge pclk);
    output_enable_n <= v;
    #1;
  endtask
endmodule

`default_nettype wire

// ### sim/tb_top.sv
/*
  Self-checking bench for the burst memory control block.
  Assumes the package and host model are compiled first; sleep is held off.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top import sram_ctrl_pkg::*; ;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  ctl_pins_s ctl;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq_in, dq_out;
  logic [DATA_W-1:0] m [DEPTH];
  logic [LANES-1:0] dq_oe;
  logic oe_n, power_down;
  int fails, tests_run;

  sync_burst_sram_control u_sync_burst_sram_control (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctl(ctl), .addr(addr),
    .dq_in(dq_in), .output_enable_n(oe_n), .sleep_request(1'b0), .dq_out(dq_out),
    .dq_oe(dq_oe), .power_down(power_down));

  host_model u_host_model (.pclk(pclk), .ctl(ctl), .addr(addr), .dq_in(dq_in),
    .output_enable_n(oe_n));

  // ----------------------------------------------------------------
  // Bus and closing tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // No cycle count assumed: a slave that never answers is left to the watchdog
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK(rd, {30'h0, CTRL_RST})
    apb(1'b1, CTRL_OFS, 32'h0);
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 12'h008, 32'h0);
    `CHK({err, rd}, 33'h100000000)
  endtask

  task automatic t_write();
    for (int i = 4; i < 8; i++) begin
      m[i] = 36'h9a5c30000 | 36'(i);
      u_host_model.pin(10'h15f, 4'(i), m[i]);
      `CHK(dq_oe, 4'h0)
    end
    u_host_model.pin(10'h167, 4'h5, 36'h0);
    m[5][8:0] = 9'h0;
    u_host_model.pin(10'h16f, 4'h6, 36'h1);
    `CHK(dq_oe, 4'h0)
    u_host_model.pin(10'h17f, 4'h5, 36'h0);
    `CHK(dq_out, m[6])
    `CHK(dq_oe, 4'hf)
    `CHK(power_down, 1'b0)
    u_host_model.pin(10'h37f, 4'h0, 36'h0);
    `CHK(dq_out, m[5])
  endtask

  task automatic t_burst();
    // Write controls low on a processor-strobe start must be ignored
    u_host_model.pin(10'h0df, 4'h4, 36'h0);
    for (int i = 0; i < 5; i++) begin
      u_host_model.pin(i == 4 ? 10'h1ff : (i == 2 ? 10'h3bf : 10'h1bf), 4'h0, 36'h0);
      `CHK(dq_out, m[4 + (i % 4)])
    end
    u_host_model.pin(10'h37f, 4'h0, 36'h0);
    `CHK(dq_out, m[4])
    u_host_model.pin(10'h37f, 4'h0, 36'h0);
    `CHK(dq_oe, 4'h0)
    `CHK(power_down, 1'b1)
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK(rd, 32'h1 << STAT_PD_BIT)
  endtask

  task automatic t_order();
    apb(1'b1, CTRL_OFS, 32'h1);
    u_host_model.pin(10'h17f, 4'h5, 36'h0);
    for (int i = 0; i < 4; i++) begin
      u_host_model.pin(10'h1bf, 4'h0, 36'h0);
      `CHK(dq_out, m[4 + (1 ^ i)])
    end
    u_host_model.pin(10'h37f, 4'h0, 36'h0);
  endtask

  task automatic t_piped();
    apb(1'b1, CTRL_OFS, 32'h2);
    u_host_model.pin(10'h17f, 4'h4, 36'h0);
    u_host_model.pin(10'h1bf, 4'h0, 36'h0);
    `CHK(dq_out, m[5])
    `CHK(dq_oe, 4'h0)
    u_host_model.pin(10'h1bf, 4'h0, 36'h0);
    `CHK(dq_out, m[4])
    `CHK(dq_oe, 4'hf)
    u_host_model.pin(10'h37f, 4'h0, 36'h0);
    u_host_model.pin(10'h37f, 4'h0, 36'h0);
    `CHK(dq_oe, 4'h0)
  endtask

  task automatic t_oe();
    apb(1'b1, CTRL_OFS, 32'h0);
    u_host_model.pin(10'h17f, 4'h4, 36'h0);
    u_host_model.pin(10'h1bf, 4'h0, 36'h0);
    `CHK(dq_oe, 4'hf)
    // Held continue command gives dummy reads while the drivers are forced off
    u_host_model.set_oe(1'b1);
    `CHK(dq_oe, 4'h0)
    `CHK(dq_out, m[5])
    u_host_model.pin(10'h15f, 4'h7, 36'h3);
    `CHK(dq_out, m[6])
    `CHK(dq_oe, 4'h0)
    u_host_model.pin(10'h37f, 4'h0, 36'h0);
    m[7] = 36'h3;
    u_host_model.set_oe(1'b0);
    u_host_model.pin(10'h17f, 4'h7, 36'h0);
    u_host_model.pin(10'h37f, 4'h0, 36'h0);
    `CHK(dq_out, m[7])
  endtask

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Whole run is under a hundred cycles; this leaves ample margin
  initial begin
    #50000;
    fails++;
    tally_and_finish();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fails = 0;
    tests_run = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_write();
    t_burst();
    t_order();
    t_piped();
    t_oe();
    tally_and_finish();
  end
endmodule

`default_nettype wire
